// *** common/emcs_pkg.sv ***
//
// Contract
// - every external cycle runs six phases
// - each phase lasts one to four half-clocks
// - after reset all phases are four long
// - wait request stretches phase four indefinitely
// - cycles even length, start on rising clock
// - odd total gets one pad half-clock
// - internal access shows address, direction, flag high
// - refresh or dma replaces internal address trace
// - address driven in phases one and two
// - data word uses bus plus two flag pins
// - read strobe low in phases four, five
// - longer phases four, five lengthen read strobe
// - write flag low on writes, then data0
// - four byte write strobes, zero is lsb
// - five general strobes, four configurable
// - refresh flag low on refresh, then data1
// - refresh enable and interval are configured
// - refresh due output high while pending
// - bus request tristates bus, raises grant
// - grant changes on output clock falling edge
// - half-clock unit is one half output period
// - seventeen built-in setups or custom data
// - strobe zero active phase two to five
// - write data driven phase three to six and pad
// - byte strobes late four-five, early three-five
package emcs_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PHASE = 8'h04;
   localparam logic [7:0] OFF_REFRESH = 8'h08;
   localparam logic [7:0] OFF_STROBE = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;

   // control fields
   localparam int CTRL_CUSTOM_BIT = 0;
   localparam int CTRL_EARLY_BIT = 1;
   localparam int CTRL_REFEN_BIT = 2;
   localparam int CTRL_IDX_LSB = 4;
   // strobe fields: s1 duration, s2..s4 delays, five bits each
   localparam int STB_S1_LSB = 0;
   localparam int STB_S2_LSB = 8;
   localparam int STB_STEP = 8;

   // reset values and built-in setup count
   localparam logic [11:0] PHASE_RST = 12'hFFF;
   localparam logic [15:0] REFRESH_RST = 16'h0100;
   localparam logic [31:0] STROBE_RST = 32'h0000_0000;
   localparam logic [4:0] BUILTIN_COUNT = 5'h11;

   // ==========================================================
   // sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_P1 = 8'h02,
      ST_P2 = 8'h04,
      ST_P3 = 8'h08,
      ST_P4 = 8'h10,
      ST_P5 = 8'h20,
      ST_P6 = 8'h40,
      ST_PAD = 8'h80
   } emcs_state_type;

   // data word as it sits on the pins: bus, data1, data0
   typedef struct packed {
      logic [29:0] ad;
      logic rd1;
      logic wd0;
   } emcs_pins_type;

   // external access request from the processor
   typedef struct packed {
      logic valid;
      logic write;
      logic [29:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } emcs_req_type;

   // internal access trace
   typedef struct packed {
      logic valid;
      logic write;
      logic [29:0] addr;
   } emcs_int_type;

endpackage

// *** verilog/emcs_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module emcs_sequencer #(
   parameter int REF_W = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // register bus, ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output var logic [31:0] hrdata,
   output logic hresp,
   // processor side
   input wire emcs_pkg::emcs_req_type ext_req,
   output logic ext_req_ready,
   output var logic ext_rsp_valid,
   output var logic [31:0] ext_rsp_rdata,
   input wire emcs_pkg::emcs_int_type int_access,
   // memory pins
   output logic cpu_clock_out,
   output emcs_pkg::emcs_pins_type pins_o,
   output emcs_pkg::emcs_pins_type pins_oe,
   input wire emcs_pkg::emcs_pins_type pins_i,
   output logic read_strobe_n,
   output logic [3:0] byte_write_strobes_n,
   output logic [4:0] general_strobes_n,
   output logic refresh_strobe_n,
   input wire logic wait_request,
   output logic refresh_due_out,
   input wire logic bus_request_in,
   output logic bus_grant_out,
   input wire logic config_select_pin
);
   import emcs_pkg::*;

   // ==========================================================
   // elaboration check
   generate
      if (REF_W < 4 || REF_W > 16) begin : g_bad_ref
         $error("REF_W must lie in 4..16");
      end
   endgenerate

   // ==========================================================
   // functions
   // length field (length minus one) of the current phase
   function automatic logic [1:0] phase_len(emcs_state_type s,
                                            logic [11:0] f);
      logic [1:0] r;
      r = 2'h0;
      case (s)
         ST_P1: r = f[1:0];
         ST_P2: r = f[3:2];
         ST_P3: r = f[5:4];
         ST_P4: r = f[7:6];
         ST_P5: r = f[9:8];
         ST_P6: r = f[11:10];
         default: r = 2'h0;
      endcase
      return r;
   endfunction

   // built-in setups: index 0 slowest, 16 fastest
   function automatic logic [11:0] builtin(logic [4:0] idx);
      logic [1:0] f;
      f = 2'h3;
      // index zero stays at four long, the shift alone would wrap it
      if (idx != 5'h00 && idx < BUILTIN_COUNT) begin
         f = 2'((5'h10 - idx) >> 2);
      end
      return {6{f}};
   endfunction

   // ==========================================================
   // registers
   logic custom_q, early_q, refen_q, sel_q, strap_done_q;
   logic [4:0] idx_q;
   logic [11:0] phase_q; // custom phase lengths
   logic [REF_W-1:0] ref_int_q;
   logic [31:0] strobe_q;
   logic wr_pend_q;
   logic [7:0] wa_q;
   // sequencer state
   emcs_state_type st_q, st_d;
   logic [1:0] cnt_q, cnt_d;
   logic par_q; // parity of elapsed half-clocks
   logic ph_q; // output clock phase, 0 = high half
   logic [11:0] len_q;
   logic wr_q, ref_q, grant_q, due_q;
   logic [29:0] addr_q, ref_row_q;
   logic [31:0] wdata_q;
   logic [3:0] be_q;
   logic [5:0] st_cnt_q; // half-clocks since phase two
   logic [REF_W-1:0] ref_cnt_q;

   // ==========================================================
   // bus slave decode
   wire ahb_take = hsel && hready && htrans[1];
   wire wr_ok = hwrite && hsize == 3'h2;
   wire [7:0] status_w = {3'h0, grant_q, due_q,
                          st_q != ST_IDLE, ref_q, wr_q};
   wire [31:0] rd_mux =
      haddr[7:0] == OFF_CTRL ? {23'h0, idx_q, 1'h0, refen_q,
                                early_q, custom_q} :
      haddr[7:0] == OFF_PHASE ? {20'h0, phase_q} :
      haddr[7:0] == OFF_REFRESH ? 32'(ref_int_q) :
      haddr[7:0] == OFF_STROBE ? strobe_q :
      haddr[7:0] == OFF_STATUS ? {24'h0, status_w} : 32'h0;
   wire wr_en = wr_pend_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // address phase capture and read data
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_pend_q <= 1'b0;
         wa_q <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         wr_pend_q <= ahb_take && wr_ok;
         if (ahb_take) begin
            wa_q <= haddr[7:0];
            hrdata <= rd_mux;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         custom_q <= 1'b0;
         early_q <= 1'b0;
         refen_q <= 1'b0;
         idx_q <= 5'h00;
         phase_q <= PHASE_RST;
         ref_int_q <= REF_W'(REFRESH_RST);
         strobe_q <= STROBE_RST;
      end else if (wr_en) begin
         if (wa_q == OFF_CTRL) begin
            custom_q <= hwdata[CTRL_CUSTOM_BIT];
            early_q <= hwdata[CTRL_EARLY_BIT];
            refen_q <= hwdata[CTRL_REFEN_BIT];
            idx_q <= hwdata[CTRL_IDX_LSB +: 5];
         end
         if (wa_q == OFF_PHASE) begin
            phase_q <= hwdata[11:0];
         end
         if (wa_q == OFF_REFRESH) begin
            ref_int_q <= hwdata[REF_W-1:0];
         end
         if (wa_q == OFF_STROBE) begin
            strobe_q <= hwdata;
         end
      end
   end

   // strap caught on the first edge after release
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         strap_done_q <= 1'b0;
         sel_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         sel_q <= config_select_pin;
      end
   end

   // ==========================================================
   // sequencer control
   // strap high picks a built-in setup unless custom is chosen
   wire [11:0] cfg_len = (custom_q || !sel_q) ? phase_q
                                              : builtin(idx_q);
   wire [1:0] cur_len = phase_len(st_q, len_q);
   wire fin = cnt_q == cur_len;
   // start only where the next half is a rising output edge
   wire start = st_q == ST_IDLE && ph_q && !grant_q &&
                !bus_request_in && (due_q || ext_req.valid);
   wire take_ref = start && due_q;
   wire expire = refen_q && ref_cnt_q == '0;
   assign ext_req_ready = start && !due_q;

   // phase sequencing
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: if (start) st_d = ST_P1;
         ST_P1: if (fin) st_d = ST_P2;
         ST_P2: if (fin) st_d = ST_P3;
         ST_P3: if (fin) st_d = ST_P4;
         ST_P4: if (fin && !wait_request) st_d = ST_P5;
         ST_P5: if (fin) st_d = ST_P6;
         ST_P6: begin
            // even elapsed count needs one pad half
            if (fin) st_d = par_q ? ST_IDLE : ST_PAD;
         end
         ST_PAD: st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   // phase counter holds at its end while waiting
   always_comb begin
      if (st_d != st_q || st_q == ST_IDLE) begin
         cnt_d = 2'h0;
      end else if (fin) begin
         cnt_d = cnt_q;
      end else begin
         cnt_d = cnt_q + 2'h1;
      end
   end

   // one clock is one half-clock unit
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ST_IDLE;
         cnt_q <= 2'h0;
         par_q <= 1'b0;
         ph_q <= 1'b0;
         st_cnt_q <= 6'h00;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ph_q <= ~ph_q;
         par_q <= (st_q == ST_IDLE) ? 1'b0 : ~par_q;
         if (st_q == ST_P1 || st_q == ST_IDLE) begin
            st_cnt_q <= 6'h00;
         end else if (st_cnt_q != 6'h3F) begin
            st_cnt_q <= st_cnt_q + 6'h01;
         end
      end
   end

   // cycle latch, read capture, response
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         len_q <= PHASE_RST;
         wr_q <= 1'b0;
         ref_q <= 1'b0;
         addr_q <= 30'h0;
         wdata_q <= 32'h0;
         be_q <= 4'h0;
         ext_rsp_valid <= 1'b0;
         ext_rsp_rdata <= 32'h0;
      end else begin
         ext_rsp_valid <= 1'b0;
         if (start) begin
            len_q <= cfg_len;
            ref_q <= take_ref;
            wr_q <= !take_ref && ext_req.write;
            addr_q <= ext_req.addr;
            wdata_q <= ext_req.wdata;
            be_q <= ext_req.be;
         end
         if (st_q == ST_P5 && fin && !ref_q) begin
            ext_rsp_valid <= 1'b1;
            if (!wr_q) begin
               ext_rsp_rdata <= pins_i;
            end
         end
      end
   end

   // refresh timer, grant on falling output edge
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ref_cnt_q <= '0;
         ref_row_q <= 30'h0;
         due_q <= 1'b0;
         grant_q <= 1'b0;
      end else begin
         if (!refen_q || expire) begin
            ref_cnt_q <= ref_int_q;
         end else begin
            ref_cnt_q <= ref_cnt_q - REF_W'(1);
         end
         due_q <= (due_q && !take_ref) || expire;
         if (take_ref) begin
            ref_row_q <= ref_row_q + 30'h1;
         end
         // ph_q low means the output clock falls next
         if (!ph_q && st_q == ST_IDLE) begin
            grant_q <= bus_request_in;
         end
      end
   end

   // ==========================================================
   // pins and strobes
   wire a_ph = st_q == ST_P1 || st_q == ST_P2;
   wire d_ph = st_q == ST_P3 || st_q == ST_P4 || st_q == ST_P5 ||
               st_q == ST_P6 || st_q == ST_PAD;
   wire rw_ph = st_q == ST_P4 || st_q == ST_P5;
   wire s0_ph = st_q == ST_P2 || st_q == ST_P3 || rw_ph;
   wire idle_int = st_q == ST_IDLE && int_access.valid && !grant_q;
   wire [31:0] be_mask = {{8{be_q[3]}}, {8{be_q[2]}},
                          {8{be_q[1]}}, {8{be_q[0]}}};
   wire [31:0] a_word = {ref_q ? ref_row_q : addr_q, ~ref_q, ~wr_q};
   wire [31:0] i_word = {int_access.addr, 1'b1, ~int_access.write};

   assign cpu_clock_out = ~ph_q;
   assign refresh_due_out = due_q;
   assign pins_o = a_ph ? a_word :
                   (d_ph && wr_q) ? wdata_q :
                   idle_int ? i_word : 32'h0000_0003;
   assign pins_oe = grant_q ? 32'h0 :
                    a_ph ? 32'hFFFF_FFFF :
                    (d_ph && wr_q) ? be_mask :
                    idle_int ? 32'hFFFF_FFFF : 32'h0;
   assign read_strobe_n = !(rw_ph && !wr_q && !ref_q);
   assign byte_write_strobes_n =
      ~(be_q & {4{wr_q && (rw_ph || (early_q && st_q == ST_P3))}});
   assign refresh_strobe_n = !(s0_ph && ref_q);
   assign general_strobes_n[0] = !s0_ph;
   // s1 starts with phase two, ends by phase six
   assign general_strobes_n[1] =
      !((s0_ph || st_q == ST_P6) &&
        st_cnt_q < 6'(strobe_q[STB_S1_LSB +: 5]));

   // s2..s4 start late and end with phase five
   genvar gi;
   generate
      for (gi = 2; gi < 5; gi++) begin : g_dly
         wire [4:0] dly = strobe_q[STB_S2_LSB + (gi - 2) * STB_STEP +: 5];
         assign general_strobes_n[gi] =
            !(s0_ph && dly != 5'h00 && st_cnt_q >= 6'(dly));
      end
   endgenerate

   // ==========================================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_p1_entered;
      st_q == ST_P1 && $past(st_q) == ST_IDLE;
   endsequence
   sequence s_p1_four;
      (st_q == ST_P1) [*4] ##1 st_q == ST_P2;
   endsequence

   property p_phase_order;
      st_q == ST_P3 && st_d != ST_P3 |=> st_q == ST_P4;
   endproperty
   a_phase_order: assert property (p_phase_order)
      else $error("phase three not followed by phase four");

   property p_len_bound;
      st_q != ST_IDLE |-> cnt_q <= cur_len;
   endproperty
   a_len_bound: assert property (p_len_bound)
      else $error("phase counter past configured length");

   property p_default_four;
      st_q == ST_P1 && $past(st_q) == ST_IDLE && len_q == PHASE_RST
         |-> s_p1_four;
   endproperty
   a_default_four: assert property (p_default_four)
      else $error("default phase one not four half-clocks");

   property p_wait;
      st_q == ST_P4 && fin && wait_request |=> st_q == ST_P4;
   endproperty
   a_wait: assert property (p_wait)
      else $error("phase four left while wait requested");

   property p_rise_start;
      s_p1_entered |-> cpu_clock_out && !$past(cpu_clock_out);
   endproperty
   a_rise_start: assert property (p_rise_start)
      else $error("phase one not on rising output clock");

   property p_even;
      st_q == ST_IDLE && $past(st_q) != ST_IDLE |-> cpu_clock_out;
   endproperty
   a_even: assert property (p_even)
      else $error("external cycle of odd length");

   property p_rd_start;
      $fell(read_strobe_n) |-> $past(st_q) == ST_P3;
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("read strobe fell outside phase four start");

   property p_grant_edge;
      $changed(bus_grant_out) |-> !cpu_clock_out &&
                                  $past(st_q) == ST_IDLE;
   endproperty
   assign bus_grant_out = grant_q;
   a_grant_edge: assert property (p_grant_edge)
      else $error("grant changed off falling edge or mid cycle");

   property p_s0_start;
      $fell(general_strobes_n[0]) |-> st_q == ST_P2 &&
                                      $past(st_q) == ST_P1;
   endproperty
   a_s0_start: assert property (p_s0_start)
      else $error("strobe zero did not start with phase two");

   property p_wflag;
      a_ph && wr_q && !grant_q |-> !pins_o.wd0 && pins_oe.wd0;
   endproperty
   a_wflag: assert property (p_wflag)
      else $error("write flag not low in address phases");

endmodule
`default_nettype wire

// *** bench/emcs_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module emcs_mem_model (
   // clock
   input wire logic clock,
   // resolved bus word and strobes
   input wire logic [31:0] bus,
   input wire logic s0_n,
   input wire logic read_strobe_n,
   input wire logic [3:0] byte_write_strobes_n,
   // wait samples asked for by the bench
   input wire logic [7:0] wait_cycles,
   // memory answers
   output logic [31:0] md,
   output logic wait_request
);
   import emcs_pkg::*;
   logic [31:0] mem [16]; // small word store
   logic [3:0] addr_q; // latched word index
   logic [31:0] last_q; // last value put out
   logic [7:0] wcnt_q; // wait samples given
   logic s0_q; // strobe zero one cycle ago
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 32'h5A5A_0000 + 32'(i);
      s0_q = 1'b1;
      wcnt_q = 8'h0;
      last_q = 32'h0;
      addr_q = 4'h0;
   end
   // data only while read strobe low, else a value that keeps moving
   assign md = read_strobe_n ? ~last_q : mem[addr_q];
   // wait held high for the asked number of samples
   assign wait_request = !read_strobe_n && (wcnt_q < wait_cycles);
   // address latch, wait count, byte lane writes
   always @(posedge clock) begin
      last_q <= md;
      s0_q <= s0_n;
      wcnt_q <= read_strobe_n ? 8'h0 : wcnt_q + 8'h1;
      if (!s0_n && s0_q) begin
         addr_q <= bus[5:2];
      end
      for (int i = 0; i < 4; i++) begin
         if (!byte_write_strobes_n[i]) begin
            mem[addr_q][8*i+:8] <= bus[8*i+:8];
         end
      end
   end
endmodule
`default_nettype wire

// *** bench/ext_memory_cycle_sequencer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_memory_cycle_sequencer_bench;
   import emcs_pkg::*;
   // ==========================================================
   // signals
   logic clock, arst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, ext_rsp_rdata, md, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   emcs_req_type ext_req;
   emcs_int_type int_access;
   emcs_pins_type pins_o, pins_oe, pins_i;
   logic ext_req_ready, ext_rsp_valid, cpu_clock_out, read_strobe_n;
   logic [3:0] byte_write_strobes_n;
   logic [4:0] general_strobes_n;
   logic refresh_strobe_n, wait_request, refresh_due_out;
   logic bus_request_in, bus_grant_out, s0_p, g_p, cur_wr;
   logic strap; // config strap, sampled after reset release
   logic [7:0] wcyc;
   int failures, tests_run, cyc, t, p1_len, n_rd, n_oe;
   int n_g [5];
   int n_b [4];
   // wire level: driven bits from the design, the rest from memory
   assign pins_i = (pins_oe & pins_o) | (~pins_oe & md);
   emcs_sequencer dut (.clock(clock), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .ext_req(ext_req),
      .ext_req_ready(ext_req_ready), .ext_rsp_valid(ext_rsp_valid),
      .ext_rsp_rdata(ext_rsp_rdata), .int_access(int_access),
      .cpu_clock_out(cpu_clock_out), .pins_o(pins_o), .pins_oe(pins_oe),
      .pins_i(pins_i), .read_strobe_n(read_strobe_n),
      .byte_write_strobes_n(byte_write_strobes_n),
      .general_strobes_n(general_strobes_n),
      .refresh_strobe_n(refresh_strobe_n), .wait_request(wait_request),
      .refresh_due_out(refresh_due_out), .bus_request_in(bus_request_in),
      .bus_grant_out(bus_grant_out), .config_select_pin(strap));
   emcs_mem_model mem (.clock(clock), .bus(pins_i),
      .s0_n(general_strobes_n[0]), .read_strobe_n(read_strobe_n),
      .byte_write_strobes_n(byte_write_strobes_n), .wait_cycles(wcyc),
      .md(md), .wait_request(wait_request));
   // ==========================================================
   // tasks
   task automatic check(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one ahb-lite single word transfer
   task automatic ahb(input logic w, input logic [31:0] a, wd,
         output logic [31:0] r);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, {24'h0, a}, d, x);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
         input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, {24'h0, a}, 32'h0, x);
      check(nm, x, e);
   endtask
   // one external memory cycle, strobe counters cleared first
   task automatic mem_op(input logic w, input logic [29:0] a,
         input logic [31:0] d, input logic [3:0] be);
      n_rd = 0;
      n_oe = 0;
      n_g = '{0, 0, 0, 0, 0};
      n_b = '{0, 0, 0, 0};
      cur_wr = w;
      @(posedge clock);
      ext_req <= '{1'b1, w, a, d, be};
      for (t = 0; t < 400 && ext_req_ready !== 1'b1; t++) @(negedge clock);
      check("ready", 32'(ext_req_ready), 32'h1);
      @(posedge clock);
      ext_req.valid <= 1'b0;
      for (t = 0; t < 400 && ext_rsp_valid !== 1'b1; t++) @(negedge clock);
      rd = ext_rsp_rdata;
      check("rsp", 32'(ext_rsp_valid), 32'h1);
      repeat (12) @(negedge clock);
      cur_wr = 1'b0;
   endtask
   // ==========================================================
   // clock, watchdog and pin monitor
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end
   always @(negedge clock) begin
      if (!read_strobe_n) n_rd++;
      for (int i = 0; i < 5; i++) if (!general_strobes_n[i]) n_g[i]++;
      for (int i = 0; i < 4; i++) if (!byte_write_strobes_n[i]) n_b[i]++;
      if (pins_oe.wd0) n_oe++;
      if (arst_n && !general_strobes_n[0] && s0_p) begin
         check("p1 align", 32'(cpu_clock_out), 32'(p1_len % 2 == 0));
         check("wr flag", 32'(pins_o.wd0), 32'(!cur_wr));
      end
      // grant may only move where the output clock falls
      if (bus_grant_out !== g_p) begin
         check("grant edge", 32'(cpu_clock_out), 0);
      end
      if (bus_grant_out && !general_strobes_n[0]) begin
         check("grant mid", 1, 0);
      end
      s0_p = general_strobes_n[0];
      g_p = bus_grant_out;
   end
   // ==========================================================
   // main sequence
   initial begin
      {arst_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      {ext_req, int_access, bus_request_in, cur_wr, wcyc, strap} = '0;
      {s0_p, g_p, p1_len} = {1'b1, 1'b0, 32'h4};
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      rchk("phase rst", OFF_PHASE, 32'h0000_0FFF);
      rchk("refresh rst", OFF_REFRESH, 32'h0000_0100);
      rchk("strobe rst", OFF_STROBE, 32'h0);
      rchk("unmapped", 8'h20, 32'h0);
      mem_op(1'b0, 30'h3, 32'h0, 4'hF);
      check("boot data", rd, 32'h5A5A_0003);
      check("boot rd", n_rd, 32'h8);
      check("boot s0", n_g[0], 32'h10);
      wr(OFF_PHASE, 32'h0);
      p1_len = 1;
      wr(OFF_STROBE, 32'h0501_0203);
      for (int k = 0; k < 2; k++) begin
         wcyc = 8'(3 * k);
         mem_op(1'b0, 30'h5, 32'h0, 4'hF);
         check("data", rd, 32'h5A5A_0005);
         check("rd len", n_rd, 2 + wcyc);
         check("s0 len", n_g[0], 4 + wcyc);
         check("s1 len", n_g[1], 32'h3);
         check("s2 len", n_g[2], 2 + wcyc);
         check("s3 len", n_g[3], 3 + wcyc);
         check("s4 len", n_g[4], k * (wcyc - 1));
      end
      mem_op(1'b1, 30'h6, 32'h1357_9BDF, 4'h5);
      check("b0 late", n_b[0], 32'h2);
      check("b1 off", n_b[1], 32'h0);
      check("d0 drive", n_oe, 32'h6);
      wr(OFF_PHASE, 32'h40);
      mem_op(1'b1, 30'h6, 32'h2468_ACE0, 4'h1);
      check("b0 long", n_b[0], 32'h3);
      check("pad drive", n_oe, 32'h8);
      wr(OFF_PHASE, 32'h0);
      wr(OFF_CTRL, 32'h2);
      mem_op(1'b1, 30'h6, 32'hFFFF_FFFF, 4'hA);
      check("b1 early", n_b[1], 32'h3);
      check("d0 tristate", n_oe, 32'h2);
      wr(OFF_CTRL, 32'h0);
      mem_op(1'b0, 30'h6, 32'h0, 4'hF);
      check("lanes", rd, 32'hFF57_FFE0);
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         int_access <= '{1'b1, k[0], 30'h2345_6789};
         repeat (3) @(negedge clock);
         check("int bus", pins_o, 32'h8D15_9E26 | 32'(!k[0]));
         check("int stb", {read_strobe_n, byte_write_strobes_n,
            general_strobes_n, refresh_strobe_n}, 32'h7FF);
      end
      wr(OFF_REFRESH, 32'h8);
      wr(OFF_CTRL, 32'h4);
      for (t = 0; t < 99 && refresh_due_out !== 1'b1; t++) @(negedge clock);
      check("due", 32'(refresh_due_out), 32'h1);
      for (t = 0; t < 99 && refresh_strobe_n !== 1'b0; t++) @(negedge clock);
      check("rf flag", {pins_oe.rd1, pins_o.rd1}, 32'h2);
      wr(OFF_CTRL, 32'h0);
      int_access <= '0;
      fork
         mem_op(1'b0, 30'h5, 32'h0, 4'hF);
         begin
            repeat (6) @(posedge clock);
            bus_request_in <= 1'b1;
         end
      join
      check("dma data", rd, 32'h5A5A_0005);
      for (t = 0; t < 50 && bus_grant_out !== 1'b1; t++) @(negedge clock);
      check("granted", 32'(bus_grant_out), 32'h1);
      check("oe off", pins_oe, 32'h0);
      // a request made while granted must wait for the release
      fork
         mem_op(1'b0, 30'h3, 32'h0, 4'hF);
         begin
            repeat (4) @(negedge clock);
            check("no take", 32'(ext_req_ready), 32'h0);
            @(posedge clock);
            bus_request_in <= 1'b0;
         end
      join
      check("released", 32'(bus_grant_out), 32'h0);
      check("after dma", rd, 32'h5A5A_0003);
      // second reset with the strap high: built-in index zero, slowest
      @(posedge clock);
      arst_n <= 1'b0;
      strap <= 1'b1;
      wcyc = 8'h0;
      p1_len = 4;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      wr(OFF_PHASE, 32'h0);
      mem_op(1'b0, 30'h5, 32'h0, 4'hF);
      check("strap rd", n_rd, 32'h8);
      check("strap data", rd, 32'h5A5A_0005);
      end_of_test();
   end
endmodule
`default_nettype wire
